// *** eewp_host.sv ***
// serial host model for the protection block
`timescale 1ns/1ps
module eewp_host (
    input  wire ref_clk,
    input  wire sdo_w,
    output reg  sel_n,
    output reg  sclk,
    output reg  sdi
);
    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        sdi   = 1'b0;
    end
    task frame(input [39:0] v, input integer n, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            @(negedge ref_clk) sel_n = 1'b0;
            #1.25; // keeps sclk and sdi edges clear of both ref_clk edges
            for (i = n - 1; i >= 0; i = i - 1) begin
                sdi = v[i];
                #62.5 sclk = 1'b1;
                rx = {rx[6:0], sdo_w};
                #62.5 sclk = 1'b0;
            end
            @(negedge ref_clk) sel_n = 1'b1;
            sdi = ~sdi;
            repeat (10) @(negedge ref_clk);
        end
    endtask
endmodule

// *** eewp_protect.v ***
// write latch, status byte and write-protect gating behind the serial port
`timescale 1ns/1ps
`include "eewp_regs.vh"
// Operation
// - set-latch command sets the latch, clear-latch command clears it.
// - array or status writes run only when the latch was already set.
// - latch clears at power-up and after clear, status write, array write.
// - status byte can be read at any time, even while busy.
// - status layout: guard enable 7, guard hi 3, lo 2, latch 1, busy 0.
// - busy flag is 1 during internal write; status write cannot change it.
// - latch flag is read-only; latch commands work even when status blocked.
// - block guard bits change only by status write and are retained.
// - guard codes protect none, 600h-7FFh, 400h-7FFh, or whole array.
// - pin guard enable bit decides whether the guard pin matters.
// - hardware protection active only with pin low and enable bit set.
// - hardware protection blocks only nonvolatile status bit writes.
// - write starts only if select rises right after a whole byte.
// - array accesses during an internal write are ignored.
// - after power-on sit in standby, output off, until select goes low.
// - opcodes are 8 bits: 06h, 04h, 05h, 01h.
// - all bytes shift most significant bit first.
// - guard pin falling after a write has begun does not affect it.
module eewp_protect #(
    parameter WRITE_CYCLES = `EEWP_WRITE_CYCLES
) (
    // clock, reset, enable
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // serial pins
    input  wire        sel_n,
    input  wire        sclk,
    input  wire        sdi,
    output reg         sdo,
    output reg         sdo_oe,
    input  wire        guard_pin_n,
    // retained bits: value restored after power-up
    input  wire [2:0]  nv_guard_init,
    // array write port and status byte
    output reg         array_wr_go,
    output reg  [10:0] array_wr_addr,
    output reg  [7:0]  array_wr_data,
    output wire        array_busy,
    output wire [7:0]  protection_status
);
    localparam ST_OP   = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_RDST = 3'h3;
    localparam ST_WRST = 3'h4;
    localparam ST_SKIP = 3'h5;
    localparam ST_CMD  = 3'h6;

    reg  [2:0]  sel_s, clk_s, di_s, gp_s;
    reg         write_latch;
    reg         pin_guard_enable, block_guard_hi, block_guard_lo;
    reg         nv_loaded;
    reg  [31:0] busy_cnt;
    reg  [2:0]  state;
    reg  [2:0]  bit_cnt;
    reg  [4:0]  addr_bits;
    reg  [7:0]  shift_in;
    reg  [7:0]  shift_out;
    reg  [7:0]  opcode;
    reg  [10:0] addr;
    reg  [7:0]  wr_data;
    reg  [7:0]  wr_status;
    reg         byte_done;
    reg         hw_block;
    wire        write_busy_flag = (busy_cnt != 32'h0);
    wire        sel_rise  = sel_s[2] == 1'b0 && sel_s[1] == 1'b1;
    wire        sel_fall  = sel_s[2] == 1'b1 && sel_s[1] == 1'b0;
    wire        clk_rise  = !sel_s[1] && clk_s[2] == 1'b0 && clk_s[1] == 1'b1;
    wire        clk_fall  = !sel_s[1] && clk_s[2] == 1'b1 && clk_s[1] == 1'b0;
    wire [7:0]  next_byte = {shift_in[6:0], di_s[1]};
    wire        hw_guard  = !gp_s[1] && pin_guard_enable;
    reg         addr_guarded;

    assign array_busy = write_busy_flag;
    assign protection_status = {pin_guard_enable, 3'h0, block_guard_hi, block_guard_lo,
                                write_latch, write_busy_flag};

    always @* begin
        case ({block_guard_hi, block_guard_lo})
            2'b01:   addr_guarded = addr >= `EEWP_BOUND_QUARTER;
            2'b10:   addr_guarded = addr >= `EEWP_BOUND_HALF;
            2'b11:   addr_guarded = 1'b1;
            default: addr_guarded = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_s <= 3'h7;
            clk_s <= 3'h0;
            di_s  <= 3'h0;
            gp_s  <= 3'h7;
        end else if (clk_en) begin
            sel_s <= {sel_s[1:0], sel_n};
            clk_s <= {clk_s[1:0], sclk};
            di_s  <= {di_s[1:0], sdi};
            gp_s  <= {gp_s[1:0], guard_pin_n};
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch      <= 1'b0;
            pin_guard_enable <= 1'b0;
            block_guard_hi   <= 1'b0;
            block_guard_lo   <= 1'b0;
            nv_loaded        <= 1'b0;
            busy_cnt         <= 32'h0;
            state            <= ST_OP;
            bit_cnt          <= 3'h0;
            addr_bits        <= 5'h0;
            shift_in         <= 8'h00;
            shift_out        <= 8'h00;
            opcode           <= 8'h00;
            addr             <= 11'h000;
            wr_data          <= 8'h00;
            wr_status        <= 8'h00;
            byte_done        <= 1'b0;
            hw_block         <= 1'b0;
            sdo              <= 1'b0;
            sdo_oe           <= 1'b0;
            array_wr_go      <= 1'b0;
            array_wr_addr    <= 11'h000;
            array_wr_data    <= 8'h00;
        end else if (clk_en) begin
            array_wr_go <= 1'b0;
            if (!nv_loaded) begin
                // retained bits restored once after reset release
                nv_loaded <= 1'b1;
                {pin_guard_enable, block_guard_hi, block_guard_lo} <= nv_guard_init;
            end
            if (busy_cnt != 32'h0)
                busy_cnt <= busy_cnt - 32'h1;
            if (sel_fall) begin
                state     <= ST_OP;
                bit_cnt   <= 3'h0;
                addr_bits <= 5'h0;
                byte_done <= 1'b0;
                sdo_oe    <= 1'b1;
            end
            if (sel_rise) begin
                sdo_oe <= 1'b0;
                state  <= ST_OP;
                // only a whole byte boundary commits
                if (byte_done && bit_cnt == 3'h0) begin
                    if (state == ST_CMD && opcode == `EEWP_OP_SET_LATCH)
                        write_latch <= 1'b1;
                    else if (state == ST_CMD && opcode == `EEWP_OP_CLR_LATCH)
                        write_latch <= 1'b0;
                    else if (state == ST_SKIP && opcode == `EEWP_OP_WR_STATUS
                             && write_latch && !write_busy_flag) begin
                        write_latch <= 1'b0;
                        if (!hw_block) begin
                            pin_guard_enable <= wr_status[`EEWP_BIT_PIN_GUARD];
                            block_guard_hi   <= wr_status[`EEWP_BIT_GUARD_HI];
                            block_guard_lo   <= wr_status[`EEWP_BIT_GUARD_LO];
                            busy_cnt <= WRITE_CYCLES;
                        end
                    end else if (state == ST_DATA && opcode == `EEWP_OP_WR_ARRAY
                                 && addr_bits == 5'h3
                                 && write_latch && !write_busy_flag) begin
                        write_latch <= 1'b0;
                        if (!addr_guarded) begin
                            array_wr_go   <= 1'b1;
                            array_wr_addr <= addr;
                            array_wr_data <= wr_data;
                            busy_cnt      <= WRITE_CYCLES;
                        end
                    end
                end
            end else if (clk_rise) begin
                shift_in <= next_byte;
                bit_cnt  <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    byte_done <= 1'b1;
                    case (state)
                        ST_OP: begin
                            opcode <= next_byte;
                            if (next_byte == `EEWP_OP_RD_STATUS) begin
                                state     <= ST_RDST;
                                shift_out <= protection_status;
                            end else if (next_byte == `EEWP_OP_WR_STATUS) begin
                                state <= ST_WRST;
                                hw_block <= hw_guard;
                            end else if (next_byte == `EEWP_OP_WR_ARRAY
                                         || next_byte == `EEWP_OP_RD_ARRAY)
                                state <= ST_ADDR;
                            else if (next_byte == `EEWP_OP_SET_LATCH
                                     || next_byte == `EEWP_OP_CLR_LATCH)
                                state <= ST_CMD; // one-byte command, extra bytes cancel it
                            else
                                state <= ST_SKIP;
                        end
                        ST_ADDR: begin
                            addr_bits <= addr_bits + 5'h1;
                            if (addr_bits[0]) begin
                                addr  <= {addr[10:8], next_byte};
                                state <= (opcode == `EEWP_OP_WR_ARRAY) ? ST_DATA : ST_SKIP;
                            end else
                                addr <= {next_byte[2:0], 8'h00};
                        end
                        ST_DATA: begin
                            wr_data   <= next_byte;
                            addr_bits <= 5'h3; // marks a whole data byte received
                        end
                        ST_WRST: begin
                            wr_status <= next_byte;
                            hw_block  <= hw_block | hw_guard;
                            state     <= ST_SKIP;
                        end
                        ST_RDST: shift_out <= protection_status;
                        default: state <= ST_SKIP;
                    endcase
                end
            end else if (clk_fall) begin
                if (state == ST_RDST) begin
                    sdo       <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end else
                    sdo <= 1'b0;
            end
        end
    end
endmodule

// *** eewp_protect_asserts.sv ***
// port assertions for the eeprom protection block
`timescale 1ns/1ps
module eewp_chk #(
    parameter WRITE_CYCLES = 20
) (
    // clock, reset, select
    input wire        ref_clk,
    input wire        rst_n,
    input wire        sel_n,
    // watched outputs
    input wire        sdo_oe,
    input wire        array_wr_go,
    input wire [10:0] array_wr_addr,
    input wire        array_busy,
    input wire [7:0]  protection_status
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [1:0] code = protection_status[3:2];
    wire       hit  = code == 2'h3 || code == 2'h2 && array_wr_addr >= 11'h400 ||
                      code == 2'h1 && array_wr_addr >= 11'h600;
    integer    busy_len;
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            busy_len <= 0;
        else
            busy_len <= array_busy ? busy_len + 1 : 0;
    a_busy_mirror: assert property (array_busy == protection_status[0]) else $error("busy");
    a_go_guarded: assert property (array_wr_go |-> !hit) else $error("guarded");
    a_go_idle: assert property (array_wr_go |-> !$past(array_busy)) else $error("go busy");
    a_go_desel: assert property (array_wr_go |-> sel_n ##1 !array_wr_go) else $error("go");
    a_go_unlatch: assert property (array_wr_go |-> ##[0:3] !protection_status[1]) else $error("latch");
    a_busy_len: assert property ($fell(array_busy) |-> busy_len >= WRITE_CYCLES - 1 &&
        busy_len <= WRITE_CYCLES + 1) else $error("busy length");
    a_idle_quiet: assert property (sel_n [*5] |-> !sdo_oe) else $error("sdo enabled");
    a_guard_hold: assert property ($changed(protection_status[7:2]) |->
        sel_n || array_busy || $past(array_busy)) else $error("guard bits");
    c_go: cover property (array_wr_go);
    c_busy: cover property ($rose(array_busy));
    c_read: cover property (sdo_oe && array_busy);
endmodule
bind eewp_protect eewp_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .sel_n(sel_n), .sdo_oe(sdo_oe), .array_wr_go(array_wr_go), .array_wr_addr(array_wr_addr),
    .array_busy(array_busy), .protection_status(protection_status));

// *** eewp_regs.vh ***
// opcodes, status field positions and timing counts of the eeprom protection block
`ifndef EEWP_REGS_VH
`define EEWP_REGS_VH
`define EEWP_OP_SET_LATCH     8'h06
`define EEWP_OP_CLR_LATCH     8'h04
`define EEWP_OP_RD_STATUS     8'h05
`define EEWP_OP_WR_STATUS     8'h01
`define EEWP_OP_RD_ARRAY      8'h03
`define EEWP_OP_WR_ARRAY      8'h02
`define EEWP_BIT_PIN_GUARD    7
`define EEWP_BIT_GUARD_HI     3
`define EEWP_BIT_GUARD_LO     2
`define EEWP_BIT_LATCH        1
`define EEWP_BIT_BUSY         0
`define EEWP_GUARD_RESET      3'h0
`define EEWP_BOUND_QUARTER    11'h600
`define EEWP_BOUND_HALF       11'h400
`define EEWP_WRITE_TIME_NS    5000000
`define EEWP_CLK_PERIOD_NS    10
`define EEWP_WRITE_CYCLES     (`EEWP_WRITE_TIME_NS / `EEWP_CLK_PERIOD_NS)
`endif

// *** tb_eeprom_write_protect_status.sv ***
// testbench for the eeprom protection block
`timescale 1ns/1ps
module tb_eeprom_write_protect_status;
    reg         ref_clk, rst_n, clk_en, guard_pin_n;
    reg  [2:0]  nv_guard_init;
    reg  [7:0]  rx;
    reg  [10:0] a;
    wire        sel_n, sclk, sdi, sdo, sdo_oe, go, busy;
    wire [10:0] wa;
    wire [7:0]  wd, st;
    wire        sdo_w = sdo_oe ? sdo : 1'bz;
    integer     fail_count = 0, samples_checked = 0, go_count = 0, cyc = 0, c, i, g, k, e;
`define CHK(x, y) begin samples_checked = samples_checked + 1; if ((x) !== (y)) begin \
    fail_count = fail_count + 1; $display("wrong value at %0t: %h vs %h", $time, x, y); end end
    eewp_protect #(.WRITE_CYCLES(1000)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .guard_pin_n(guard_pin_n),
        .nv_guard_init(nv_guard_init), .array_wr_go(go), .array_wr_addr(wa), .array_wr_data(wd),
        .array_busy(busy), .protection_status(st));
    eewp_host host (.ref_clk(ref_clk), .sdo_w(sdo_w), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        go_count <= go_count + go;
        if (cyc == 70000) begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    task send(input [39:0] v, input integer n);
        host.frame(v, n, rx);
    endtask
    task idle;
        begin
            for (c = 0; c < 1200 && busy !== 1'b0; c = c + 1) @(negedge ref_clk);
            `CHK(busy, 1'b0)
        end
    endtask
    task wsr(input [7:0] v);
        begin
            send(8'h06, 8);
            send({8'h01, v}, 16);
            idle;
        end
    endtask
    task t_latch;
        begin
            send(16'h0100, 16);
            `CHK(st, 8'h08)
            send(8'h06, 8);
            `CHK(st, 8'h0A)
            send(8'h04, 8);
            `CHK(st, 8'h08)
            send(24'h060100, 24);
            `CHK(st, 8'h08)
            send(8'h06, 8);
            send(16'h01FF, 16);
            send(16'h0500, 16);
            `CHK(rx[0], 1'b1)
            idle;
            send(16'h0500, 16);
            `CHK(rx, 8'h8C)
            $display("latch and status test done");
        end
    endtask
    task t_guard;
        begin
            guard_pin_n = 1'b0;
            wsr(8'h00);
            `CHK(st, 8'h8C)
            send(8'h06, 8);
            `CHK(st, 8'h8E)
            guard_pin_n = 1'b1;
            wsr(8'h04);
            `CHK(st, 8'h04)
            guard_pin_n = 1'b0;
            wsr(8'h88);
            `CHK(st, 8'h88)
            guard_pin_n = 1'b1;
            send(8'h06, 8);
            send(16'h0184, 16);
            guard_pin_n = 1'b0;
            idle;
            `CHK(st, 8'h84)
            guard_pin_n = 1'b1;
            $display("guard test done");
        end
    endtask
    task t_array;
        for (i = 0; i < 4; i = i + 1) begin
            wsr({i[1:0], 2'b00});
            for (g = 0; g < 3; g = g + 1) begin
                a = g == 0 ? 11'h3FF : g == 1 ? 11'h5FF : 11'h600;
                e = i == 0 || i == 1 && a < 11'h600 || i == 2 && a < 11'h400;
                k = go_count;
                send(8'h06, 8);
                send({8'h02, 5'h00, a, 8'h96}, 32);
                `CHK(go_count - k, e)
                if (e) `CHK({wa, wd}, {a, 8'h96})
                `CHK(st[1], 1'b0)
                idle;
            end
            $display("array code %0d done", i);
        end
    endtask
    task t_abort;
        begin
            wsr(8'h00);
            k = go_count;
            send(8'h06, 8);
            send(32'h02001096 >> 1, 31);
            send(24'h020010, 24);
            `CHK(go_count, k)
            send(8'h06, 8);
            send(32'h02002096, 32);
            send(8'h06, 8);
            send(32'h02003096, 32);
            `CHK(go_count, k + 1)
            `CHK(wa, 11'h020)
            idle;
            $display("abort test done");
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        guard_pin_n = 1'b1;
        nv_guard_init = 3'b010;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK(st, 8'h08)
        `CHK(sdo_oe, 1'b0)
        t_latch;
        t_guard;
        t_array;
        t_abort;
        final_report;
    end
endmodule
